/* design/csg_security_gate.sv */
// chip security gate: decodes the security state at reset and gates
// debug unit commands by security and operating mode, nvm commands by security alone.
// assumes security_field is stable from the options byte during reset and
// that the mode pin is a strap held steady around reset release.
//
// Contract
// R1 - only security field pattern 10 unsecures; 00, 01, 11 mean secured
// R2 - secured normal single chip: debug unit fully off, no command serviced
// R3 - secured in either mode: restrict flash/eeprom commands, refuse excluded ones
// R4 - secured special mode: debug accepts only mass erase and control/status access
// R5 - special single chip mode leaves reset with active debug mode on
// R6 - secured special mode: block memory reads/writes, erase still allowed
// R7 - after a good full erase, program security field to the unsecured value
// R8 - reprogrammed unsecured field takes effect only at the next reset
// R9 - host software never uses key words 0x0000 or 0xFFFF
// R10 - sample security field during reset, hold state until next reset
`timescale 1ns/10ps
module csg_security_gate (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// options byte and mode strap
	input wire logic [csg_pkg::SEC_W-1:0] security_field,
	input wire logic special_mode_pin,
	// debug unit command request and answer
	input wire csg_pkg::csg_dbg_req_t dbg_req,
	output csg_pkg::csg_answer_t dbg_answer,
	// nvm command request and answer
	input wire csg_pkg::csg_nvm_req_t nvm_req,
	output csg_pkg::csg_answer_t nvm_answer,
	// nvm erase completion and security write-back
	input wire logic erase_all_done,
	input wire logic erase_all_ok,
	input wire logic sec_prog_ack,
	output logic sec_prog_req,
	output logic [csg_pkg::SEC_W-1:0] sec_prog_value,
	// state seen by the rest of the chip
	output logic ready,
	output logic secured,
	output logic special_single_chip,
	output logic background_debug_unit_enable,
	output logic active_debug_mode,
	output logic unsecure_pending
);

	typedef enum logic [1:0] {
		PH_SETTLE,
		PH_CAPTURE,
		PH_RUN
	} csg_phase_t;

	typedef struct packed {
		csg_phase_t phase;
		logic [2:0] settle;
		logic ready;
		logic secured;
		logic special;
		logic dbg_enable;
		logic active_dbg;
		csg_pkg::csg_answer_t dbg_ans;
		csg_pkg::csg_answer_t nvm_ans;
		logic prog_req;
		logic pending;
	} csg_state_t;

	localparam csg_state_t RESET_STATE = '{
		phase: PH_SETTLE,
		settle: 3'h0,
		ready: 1'b0,
		secured: 1'b1,
		special: 1'b0,
		dbg_enable: 1'b0,
		active_dbg: 1'b0,
		dbg_ans: '{grant: 1'b0, refuse: 1'b0},
		nvm_ans: '{grant: 1'b0, refuse: 1'b0},
		prog_req: 1'b0,
		pending: 1'b0
	};

	logic rst_meta;
	logic rst_n;
	logic special_pin_clean;
	csg_state_t st;
	csg_state_t next_st;

	// anything other than the single open pattern fails safe to secured
	function automatic logic decode_secured(input logic [csg_pkg::SEC_W-1:0] field);
		return field != csg_pkg::SEC_UNSECURED; // [R1]
	endfunction : decode_secured

	function automatic logic dbg_allowed(input logic sec, input logic spec,
			input csg_pkg::csg_dbg_cmd_t cmd);
		logic ok;
		ok = 1'b1;
		if (sec && !spec) begin
			ok = 1'b0; // [R2]
		end else if (sec) begin
			// memory-mapped reads and writes stay blocked, erase still works
			ok = (cmd == csg_pkg::DBG_MASS_ERASE) || (cmd == csg_pkg::DBG_CSR_ACCESS); // [R4] [R6]
		end
		return ok;
	endfunction : dbg_allowed

	function automatic logic nvm_allowed(input logic sec, input csg_pkg::csg_nvm_cmd_t cmd);
		logic ok;
		ok = 1'b1;
		if (sec) begin
			ok = csg_pkg::NVM_SECURE_ALLOWED[cmd]; // [R3]
		end
		return ok;
	endfunction : nvm_allowed

	// reset released through two flops so all state leaves reset together
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	csg_pin_sync #(
		.INIT(1'b0)
	) u_mode_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din(special_mode_pin),
		.dout(special_pin_clean)
	);

	always_comb begin
		next_st = st;
		next_st.dbg_ans = '{grant: 1'b0, refuse: 1'b0};
		next_st.nvm_ans = '{grant: 1'b0, refuse: 1'b0};
		unique case (st.phase)
			PH_SETTLE: begin
				// wait out the synchroniser before trusting the strap
				next_st.settle = st.settle + 3'h1;
				if (st.settle == csg_pkg::SETTLE_CYCLES) begin
					next_st.phase = PH_CAPTURE;
				end
			end
			PH_CAPTURE: begin
				// latched once per reset; nothing later can change it
				next_st.secured = decode_secured(security_field); // [R10]
				next_st.special = special_pin_clean;
				// special mode enters debug mode whatever the security
				next_st.active_dbg = special_pin_clean; // [R5]
				next_st.dbg_enable = !(decode_secured(security_field) && !special_pin_clean); // [R2]
				next_st.ready = 1'b1;
				next_st.phase = PH_RUN;
			end
			PH_RUN: begin
				if (dbg_req.valid) begin
					if (dbg_allowed(st.secured, st.special, dbg_req.cmd)) begin
						next_st.dbg_ans.grant = 1'b1;
					end else begin
						next_st.dbg_ans.refuse = 1'b1; // [R2] [R4] [R6]
					end
				end
				if (nvm_req.valid) begin
					if (nvm_allowed(st.secured, nvm_req.cmd)) begin
						next_st.nvm_ans.grant = 1'b1;
					end else begin
						next_st.nvm_ans.refuse = 1'b1; // [R3]
					end
				end
				// write-back request holds until the nvm logic takes it
				if (st.prog_req && sec_prog_ack) begin
					next_st.prog_req = 1'b0;
				end
				if (erase_all_done && erase_all_ok) begin
					next_st.prog_req = 1'b1; // [R7]
					next_st.pending = st.secured;
				end
				// secured is deliberately left alone: opens at next reset only
				next_st.secured = st.secured; // [R8]
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= RESET_STATE;
		end else begin
			st <= next_st;
		end
	end

	assign dbg_answer = st.dbg_ans;
	assign nvm_answer = st.nvm_ans;
	assign sec_prog_req = st.prog_req;
	assign sec_prog_value = csg_pkg::SEC_PROGRAM_VALUE;
	assign ready = st.ready;
	assign secured = st.secured;
	assign special_single_chip = st.special;
	assign background_debug_unit_enable = st.dbg_enable;
	assign active_debug_mode = st.active_dbg;
	assign unsecure_pending = st.pending;

endmodule : csg_security_gate

/* design/csg_pkg.sv */
// chip security gate: shared types and constants
// assumes all users reference items as csg_pkg::name
package csg_pkg;

	localparam int SEC_W = 2;
	// the one pattern of the security field that leaves the part open
	localparam logic [SEC_W-1:0] SEC_UNSECURED = 2'h2;
	// pattern the nvm logic writes back after a full erase
	localparam logic [SEC_W-1:0] SEC_PROGRAM_VALUE = 2'h2;

	// cycles waited after reset release so the mode pin synchroniser has settled
	localparam logic [2:0] SETTLE_CYCLES = 3'h4;

	// invalid back-door key words, used by the bench's host key check
	localparam logic [15:0] KEY_INVALID_LO = 16'h0000;
	localparam logic [15:0] KEY_INVALID_HI = 16'hFFFF;

	typedef enum logic [2:0] {
		DBG_CSR_ACCESS,
		DBG_MASS_ERASE,
		DBG_MEM_READ,
		DBG_MEM_WRITE,
		DBG_OTHER
	} csg_dbg_cmd_t;

	typedef enum logic [2:0] {
		NVM_ERASE_ALL,
		NVM_ERASE_VERIFY_ALL,
		NVM_PROGRAM,
		NVM_ERASE_SECTOR,
		NVM_READ_ONCE,
		NVM_OTHER
	} csg_nvm_cmd_t;

	localparam int NVM_CLASSES = 6;
	// classes still allowed while secured: full erase and its blank check
	localparam logic [NVM_CLASSES-1:0] NVM_SECURE_ALLOWED = 6'h03;

	typedef struct packed {
		logic valid;
		csg_dbg_cmd_t cmd;
	} csg_dbg_req_t;

	typedef struct packed {
		logic valid;
		csg_nvm_cmd_t cmd;
	} csg_nvm_req_t;

	typedef struct packed {
		logic grant;
		logic refuse;
	} csg_answer_t;

endpackage : csg_pkg

/* design/csg_pin_sync.sv */
// chip security gate: three-flop pin synchroniser with agreement filter
// assumes din is asynchronous to clk; rst_n is already synchronised
`timescale 1ns/10ps
module csg_pin_sync #(
	parameter logic INIT = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pin and clean level
	input wire logic din,
	output logic dout
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} csg_sync_state_t;

	csg_sync_state_t st;
	csg_sync_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// s1 feeds only s2; a change counts once s2 and s3 agree
		if (st.s2 == st.s3) begin
			next_st.level = st.s3;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{s1: INIT, s2: INIT, s3: INIT, level: INIT};
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.level;

endmodule : csg_pin_sync

/* dv/csg_nvm_model.sv */
// nvm side model: acks the security write-back, promptly or slowly
// assumes the gate's clock
`timescale 1ns/10ps
module csg_nvm_model (
	// clock and mode
	input wire logic clk,
	input wire logic slow,
	// write-back handshake
	input wire logic sec_prog_req,
	output logic sec_prog_ack
);
	logic [3:0] cnt = 4'h0;
	initial sec_prog_ack = 1'b0;
	always @(posedge clk) begin
		cnt <= sec_prog_req ? cnt + 4'h1 : 4'h0;
		sec_prog_ack <= sec_prog_req && cnt >= (slow ? 4'h6 : 4'h0);
	end
endmodule : csg_nvm_model

/* dv/csg_security_gate_sva.sv */
// checker for the security gate
// assumes binding onto csg_security_gate
`timescale 1ns/10ps
module csg_security_gate_sva (
	// observed ports
	input wire logic clk,
	input wire logic nrst,
	input wire logic [csg_pkg::SEC_W-1:0] security_field,
	input wire csg_pkg::csg_dbg_req_t dbg_req,
	input wire csg_pkg::csg_answer_t dbg_answer,
	input wire csg_pkg::csg_nvm_req_t nvm_req,
	input wire csg_pkg::csg_answer_t nvm_answer,
	input wire logic erase_all_done,
	input wire logic erase_all_ok,
	input wire logic sec_prog_req,
	input wire logic [csg_pkg::SEC_W-1:0] sec_prog_value,
	input wire logic ready,
	input wire logic secured,
	input wire logic special_single_chip,
	input wire logic background_debug_unit_enable,
	input wire logic active_debug_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_sec_decode: assert property ($rose(ready) |-> secured == (security_field != 2'h2))
		else $error("security decode wrong");
	a_bdu_off: assert property (ready && secured && !special_single_chip |->
		!background_debug_unit_enable) else $error("debug unit left on");
	a_ns_refuse: assert property (ready && dbg_req.valid && secured && !special_single_chip
		|=> dbg_answer == 2'h1) else $error("debug command not refused");
	a_ss_filter: assert property (ready && dbg_req.valid && secured && special_single_chip
		|=> dbg_answer == {$past(dbg_req.cmd) <= 1, $past(dbg_req.cmd) > 1})
		else $error("special mode debug filter wrong");
	a_nvm_filter: assert property (ready && nvm_req.valid |=> nvm_answer.grant
		== (!secured || $past(nvm_req.cmd) <= 1)) else $error("nvm filter wrong");
	a_active_dbg: assert property ($rose(ready) |-> active_debug_mode == special_single_chip)
		else $error("active debug mode wrong");
	a_erase_req: assert property (ready && erase_all_done && erase_all_ok |=> sec_prog_req
		&& sec_prog_value == 2'h2) else $error("no write-back request");
	a_sec_hold: assert property (ready |=> ready && $stable(secured))
		else $error("secured state moved");
	c_ss_dbg: cover property (ready && dbg_req.valid && secured && special_single_chip);
	c_open: cover property ($rose(ready) && !secured);
	c_wb: cover property ($fell(sec_prog_req));
endmodule : csg_security_gate_sva
bind csg_security_gate csg_security_gate_sva chk (.clk, .nrst, .security_field, .dbg_req,
	.dbg_answer, .nvm_req, .nvm_answer, .erase_all_done, .erase_all_ok, .sec_prog_req,
	.sec_prog_value, .ready, .secured, .special_single_chip, .background_debug_unit_enable,
	.active_debug_mode);

/* dv/csg_security_gate_tb.sv */
// bench for the security gate: all field patterns and modes
// assumes package, gate, nvm model and checker compiled first
`timescale 1ns/10ps
module csg_security_gate_tb;
	logic clk = 1'b0, nrst = 1'b0, special_mode_pin = 1'b0, slow = 1'b0, sec_e, ss_e;
	logic erase_all_done = 1'b0, erase_all_ok = 1'b0, sec_prog_ack, sec_prog_req, ready;
	logic secured, special_single_chip, bdu_en, active_debug_mode, unsecure_pending;
	logic [1:0] security_field = 2'h0, sec_prog_value;
	csg_pkg::csg_dbg_req_t dbg_req = '0;
	csg_pkg::csg_nvm_req_t nvm_req = '0;
	csg_pkg::csg_answer_t dbg_answer, nvm_answer;
	int errors = 0, compares = 0, seed = 6491, pd = -1, pn = -1;
	csg_security_gate uut (.clk, .nrst, .security_field, .special_mode_pin, .dbg_req,
		.dbg_answer, .nvm_req, .nvm_answer, .erase_all_done, .erase_all_ok, .sec_prog_ack,
		.sec_prog_req, .sec_prog_value, .ready, .secured, .special_single_chip,
		.background_debug_unit_enable(bdu_en), .active_debug_mode, .unsecure_pending);
	csg_nvm_model nvm (.clk, .slow, .sec_prog_req, .sec_prog_ack);
	initial forever #12.5 clk = ~clk;
	initial begin
		#200000;
		errors++;
		complete_run();
	end
	task automatic complete_run;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t flag %b want %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_ans(input csg_pkg::csg_answer_t got, input logic [1:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t answer %b want %b", $time, got, exp);
		end
	endtask : chk_ans
	function automatic logic dbg_ok(input int c);
		return !sec_e || (ss_e && c <= 1);
	endfunction : dbg_ok
	function automatic logic nvm_ok(input int c);
		return !sec_e || c <= 1;
	endfunction : nvm_ok
	// checks last cycle's answers, then drives the next pair; -1 means idle
	task automatic step(input int dc, input int nc);
		@(negedge clk);
		chk_ans(dbg_answer, pd < 0 ? 2'h0 : {dbg_ok(pd), !dbg_ok(pd)});
		chk_ans(nvm_answer, pn < 0 ? 2'h0 : {nvm_ok(pn), !nvm_ok(pn)});
		dbg_req.valid = dc >= 0;
		dbg_req.cmd = csg_pkg::csg_dbg_cmd_t'(dc[2:0]);
		nvm_req.valid = nc >= 0;
		nvm_req.cmd = csg_pkg::csg_nvm_cmd_t'(nc[2:0]);
		pd = dc;
		pn = nc;
	endtask : step
	task automatic run_case(input logic [1:0] f, input logic m);
		int i;
		@(negedge clk);
		nrst = 1'b0;
		security_field = f;
		special_mode_pin = m;
		sec_e = f != 2'h2;
		ss_e = m;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		for (i = 0; i < 20 && ready !== 1'b1; i++) @(negedge clk);
		chk_bit(secured, sec_e);
		chk_bit(bdu_en, !(sec_e && !m));
		chk_bit(active_debug_mode, m);
		chk_bit(special_single_chip, m);
		for (i = 0; i < 7; i++) step(i < 5 ? i : -1, i < 6 ? i : -1);
		repeat (12) step(int'($unsigned($random(seed)) % 6) - 1,
			int'($unsigned($random(seed)) % 7) - 1);
		step(-1, -1);
		// erase done first without success, then with success; the write-back must start
		erase_all_done = 1'b1;
		@(negedge clk);
		erase_all_ok = 1'b1;
		@(negedge clk);
		erase_all_done = 1'b0;
		erase_all_ok = 1'b0;
		security_field = ~f;
		chk_bit(sec_prog_req, 1'b1);
		chk_bit(sec_prog_value == 2'h2, 1'b1);
		chk_bit(unsecure_pending, sec_e);
		for (i = 0; i < 20 && sec_prog_req !== 1'b0; i++) @(negedge clk);
		chk_bit(sec_prog_req, 1'b0);
		chk_bit(secured, sec_e);
	endtask : run_case
	initial begin
		int f;
		logic [15:0] key;
		// host side never offers the two reserved key words
		key = 16'($random(seed));
		if (key == csg_pkg::KEY_INVALID_LO || key == csg_pkg::KEY_INVALID_HI) key = 16'h5A5A;
		chk_bit(key != csg_pkg::KEY_INVALID_LO && key != csg_pkg::KEY_INVALID_HI, 1'b1);
		for (f = 0; f < 8; f++) begin
			slow = f[0];
			run_case(f[2:1], f[0]);
		end
		complete_run();
	end
endmodule : csg_security_gate_tb
